/* File: logic/tmr_clk_gen.sv */
// Count enables: core clock divided by 12, external oscillator divided by 8.
// Assumes the external oscillator is far slower than the core clock.
`timescale 1ns/1ps
`default_nettype none

module tmr_clk_gen #(
   parameter int CORE_DIV = tmr_pkg::CORE_DIV,
   parameter int EXT_DIV  = tmr_pkg::EXT_DIV
) (
   input  wire logic  sys_clk,
   input  wire logic  resetn,
   input  wire logic  ext_osc,
   tmr_tick_if.clk_src ticks
);

   // Dividers must fit the 8-bit counters
   if (CORE_DIV < 2 || CORE_DIV > 256 || EXT_DIV < 2 || EXT_DIV > 256) begin
      $error("tmr_clk_gen: divider out of range");
   end

   logic [7:0] core_cnt;
   logic [7:0] ext_cnt;
   logic       ext_s1;
   logic       ext_s2;
   logic       ext_s3;

   // ****************************************
   // Core clock divider
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         core_cnt        <= 8'h00;
         ticks.core_tick <= 1'b0;
      end else if (core_cnt == 8'(CORE_DIV - 1)) begin
         core_cnt        <= 8'h00;
         ticks.core_tick <= 1'b1;
      end else begin
         core_cnt        <= core_cnt + 8'h01;
         ticks.core_tick <= 1'b0;
      end
   end

   // ****************************************
   // External oscillator sync and divider
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_s3 <= 1'b0;
      end else begin
         ext_s1 <= ext_osc;
         ext_s2 <= ext_s1;
         ext_s3 <= ext_s2;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_cnt        <= 8'h00;
         ticks.ext_tick <= 1'b0;
      end else if (ext_s2 && !ext_s3) begin
         ext_cnt        <= (ext_cnt == 8'(EXT_DIV - 1)) ? 8'h00 : ext_cnt + 8'h01;
         ticks.ext_tick <= (ext_cnt == 8'(EXT_DIV - 1));
      end else begin
         ticks.ext_tick <= 1'b0;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   a_core_tick_rate: assert property (@(posedge sys_clk) disable iff (!resetn)
      ticks.core_tick |=> (!ticks.core_tick) [*8] ##1 !ticks.core_tick ##1 !ticks.core_tick
                          ##1 !ticks.core_tick ##1 ticks.core_tick)
      else $error("core tick spacing is not twelve cycles");

endmodule

`default_nettype wire

/* File: logic/tmr_osc_edge.sv */
// Finds falling edges of the low-frequency oscillator after synchronising it.
// Assumes the oscillator stays at each level for at least two core clocks.
`timescale 1ns/1ps
`default_nettype none

module tmr_osc_edge (
   input  wire logic    sys_clk,
   input  wire logic    resetn,
   input  wire logic    low_freq_oscillator,
   tmr_tick_if.edge_src ticks
);

   logic s1;
   logic s2;
   logic s3;

   // ****************************************
   // Synchroniser and edge detector
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= low_freq_oscillator;
         s2 <= s1;
         s3 <= s2;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ticks.osc_fall <= 1'b0;
      end else begin
         ticks.osc_fall <= s3 && !s2;
      end
   end

   a_single_fall: assert property (@(posedge sys_clk) disable iff (!resetn)
      ticks.osc_fall |=> !ticks.osc_fall)
      else $error("oscillator edge pulse lasted more than one cycle");

endmodule

`default_nettype wire

/* File: logic/tmr_pkg.sv */
// Constants for the timer control and reload slice: addresses, field positions, resets, divider counts.
// Assumes an 8-bit special-function register bus and a single core clock.

package tmr_pkg;

   // ****************************************
   // Register addresses
   // ****************************************
   localparam logic [7:0] ADDR_CONTROL     = 8'hc8;
   localparam logic [7:0] ADDR_RELOAD_LOW  = 8'hca;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
   localparam logic [7:0] ADDR_COUNT_LOW   = 8'hcc;
   localparam logic [7:0] ADDR_COUNT_HIGH  = 8'hcd;

   // ****************************************
   // Control field positions
   // ****************************************
   localparam int BIT_HIGH_FLAG  = 7;
   localparam int BIT_LOW_FLAG   = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_CAPTURE_EN = 4;
   localparam int BIT_SPLIT      = 3;
   localparam int BIT_RUN        = 2;
   localparam int BIT_EXT_CLK    = 0;

   // ****************************************
   // Reset values and byte maximum
   // ****************************************
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX   = 8'hff;

   // ****************************************
   // Clock dividers
   // ****************************************
   localparam int CORE_DIV = 12;
   localparam int EXT_DIV  = 8;

endpackage

/* File: logic/tmr_tick_if.sv */
// Carrier for count enables and the oscillator edge pulse between timer modules.
// Assumes all members are one-cycle pulses in the core clock domain.
`timescale 1ns/1ps
`default_nettype none

interface tmr_tick_if;
   logic core_tick;
   logic ext_tick;
   logic osc_fall;

   modport clk_src  (output core_tick, output ext_tick);
   modport edge_src (output osc_fall);
   modport sink     (input core_tick, input ext_tick, input osc_fall);
endinterface

`default_nettype wire

/* File: logic/tmr_timer.sv */
// Timer top: control, reload and count registers on the special-function bus, counters, capture.
// Assumes the CPU interrupt enable and the two byte clock selects arrive as synchronous levels.
`timescale 1ns/1ps
`default_nettype none

module tmr_timer (
   input  wire logic       sys_clk,
   input  wire logic       resetn,
   input  wire logic [7:0] sfr_addr,
   input  wire logic       sfr_wr,
   input  wire logic       sfr_rd,
   input  wire logic [7:0] sfr_wdata,
   output logic      [7:0] sfr_rdata,
   input  wire logic       cpu_irq_enable,
   input  wire logic       high_byte_clock_select,
   input  wire logic       low_byte_clock_select,
   input  wire logic       ext_osc,
   input  wire logic       low_freq_oscillator,
   output logic            irq_req
);

   // ****************************************
   // Register state
   // ****************************************
   logic       high_overflow_flag;
   logic       low_overflow_flag;
   logic       low_byte_irq_enable;
   logic       osc_capture_enable;
   logic       split_mode;
   logic       run_control;
   logic       ext_clock_select;
   logic [7:0] timer_reload_low;
   logic [7:0] timer_reload_high;
   logic [7:0] timer_count_low;
   logic [7:0] timer_count_high;

   logic [7:0] next_count_low;
   logic [7:0] next_count_high;
   logic       set_high;
   logic       set_low;
   logic       tick_low;
   logic       tick_high;
   logic       capture;
   logic       wr_ctrl;
   logic       wr_rll;
   logic       wr_rlh;
   logic       wr_cl;
   logic       wr_ch;

   tmr_tick_if ticks ();

   tmr_clk_gen u_clk_gen (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .ext_osc (ext_osc),
      .ticks   (ticks.clk_src)
   );

   tmr_osc_edge u_osc_edge (
      .sys_clk             (sys_clk),
      .resetn              (resetn),
      .low_freq_oscillator (low_freq_oscillator),
      .ticks               (ticks.edge_src)
   );

   // ****************************************
   // Bus decode
   // ****************************************
   assign wr_ctrl = sfr_wr && (sfr_addr == tmr_pkg::ADDR_CONTROL);
   assign wr_rll  = sfr_wr && (sfr_addr == tmr_pkg::ADDR_RELOAD_LOW);
   assign wr_rlh  = sfr_wr && (sfr_addr == tmr_pkg::ADDR_RELOAD_HIGH);
   assign wr_cl   = sfr_wr && (sfr_addr == tmr_pkg::ADDR_COUNT_LOW);
   assign wr_ch   = sfr_wr && (sfr_addr == tmr_pkg::ADDR_COUNT_HIGH);

   // ****************************************
   // Clock source selection
   // ****************************************
   // Byte select set: every core clock; else external or divide-by-12 enable
   assign tick_low  = low_byte_clock_select ? 1'b1 :
                      (ext_clock_select ? ticks.ext_tick : ticks.core_tick);
   assign tick_high = high_byte_clock_select ? 1'b1 :
                      (ext_clock_select ? ticks.ext_tick : ticks.core_tick);
   assign capture   = osc_capture_enable && ticks.osc_fall;

   // ****************************************
   // Counter next state
   // ****************************************
   always_comb begin
      next_count_low  = timer_count_low;
      next_count_high = timer_count_high;
      set_low         = 1'b0;
      set_high        = capture;
      if (!split_mode) begin
         if (run_control && tick_low) begin
            if ({timer_count_high, timer_count_low} == {tmr_pkg::BYTE_MAX, tmr_pkg::BYTE_MAX}) begin
               {next_count_high, next_count_low} = {timer_reload_high, timer_reload_low};
               set_high = 1'b1;
            end else begin
               {next_count_high, next_count_low} = {timer_count_high, timer_count_low} + 16'h0001;
            end
            set_low = (timer_count_low == tmr_pkg::BYTE_MAX);
         end
      end else begin
         if (tick_low) begin
            if (timer_count_low == tmr_pkg::BYTE_MAX) begin
               next_count_low = timer_reload_low;
               set_low        = 1'b1;
            end else begin
               next_count_low = timer_count_low + 8'h01;
            end
         end
         if (run_control && tick_high) begin
            if (timer_count_high == tmr_pkg::BYTE_MAX) begin
               next_count_high = timer_reload_high;
               set_high        = 1'b1;
            end else begin
               next_count_high = timer_count_high + 8'h01;
            end
         end
      end
      if (wr_cl) begin
         next_count_low = sfr_wdata;
      end
      if (wr_ch) begin
         next_count_high = sfr_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         timer_count_low  <= tmr_pkg::RESET_BYTE;
         timer_count_high <= tmr_pkg::RESET_BYTE;
      end else begin
         timer_count_low  <= next_count_low;
         timer_count_high <= next_count_high;
      end
   end

   // ****************************************
   // Control register
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         low_byte_irq_enable <= 1'b0;
         osc_capture_enable  <= 1'b0;
         split_mode          <= 1'b0;
         run_control         <= 1'b0;
         ext_clock_select    <= 1'b0;
      end else if (wr_ctrl) begin
         low_byte_irq_enable <= sfr_wdata[tmr_pkg::BIT_LOW_IRQ_EN];
         osc_capture_enable  <= sfr_wdata[tmr_pkg::BIT_CAPTURE_EN];
         split_mode          <= sfr_wdata[tmr_pkg::BIT_SPLIT];
         run_control         <= sfr_wdata[tmr_pkg::BIT_RUN];
         ext_clock_select    <= sfr_wdata[tmr_pkg::BIT_EXT_CLK];
      end
   end

   // Hardware set wins over a software write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         high_overflow_flag <= 1'b0;
         low_overflow_flag  <= 1'b0;
      end else begin
         high_overflow_flag <= (wr_ctrl ? sfr_wdata[tmr_pkg::BIT_HIGH_FLAG] : high_overflow_flag)
                               | set_high;
         low_overflow_flag  <= (wr_ctrl ? sfr_wdata[tmr_pkg::BIT_LOW_FLAG] : low_overflow_flag)
                               | set_low;
      end
   end

   // ****************************************
   // Reload registers and capture
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         timer_reload_low  <= tmr_pkg::RESET_BYTE;
         timer_reload_high <= tmr_pkg::RESET_BYTE;
      end else if (capture) begin
         timer_reload_low  <= timer_count_low;
         timer_reload_high <= timer_count_high;
      end else begin
         if (wr_rll) begin
            timer_reload_low <= sfr_wdata;
         end
         if (wr_rlh) begin
            timer_reload_high <= sfr_wdata;
         end
      end
   end

   // ****************************************
   // Read data and interrupt
   // ****************************************
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_rd) begin
         unique case (sfr_addr)
            tmr_pkg::ADDR_CONTROL:     sfr_rdata <= {high_overflow_flag, low_overflow_flag,
                                                     low_byte_irq_enable, osc_capture_enable,
                                                     split_mode, run_control, 1'b0, ext_clock_select};
            tmr_pkg::ADDR_RELOAD_LOW:  sfr_rdata <= timer_reload_low;
            tmr_pkg::ADDR_RELOAD_HIGH: sfr_rdata <= timer_reload_high;
            tmr_pkg::ADDR_COUNT_LOW:   sfr_rdata <= timer_count_low;
            tmr_pkg::ADDR_COUNT_HIGH:  sfr_rdata <= timer_count_high;
            default:                   sfr_rdata <= 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= cpu_irq_enable && (high_overflow_flag ||
                    (low_overflow_flag && low_byte_irq_enable));
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_reload_on_wrap: assert property (
      !split_mode && run_control && tick_low && !wr_cl && !wr_ch && !capture &&
      {timer_count_high, timer_count_low} == 16'hffff
      |=> {timer_count_high, timer_count_low} == $past({timer_reload_high, timer_reload_low})
          && high_overflow_flag)
      else $error("16-bit wrap did not reload or flag");

   a_hold_stopped: assert property (
      !split_mode && !run_control && !wr_cl && !wr_ch
      |=> $stable({timer_count_high, timer_count_low}))
      else $error("16-bit counter moved while stopped");

   a_low_free_split: assert property (
      split_mode && !run_control && tick_low && !wr_cl && timer_count_low != 8'hff
      |=> timer_count_low == $past(timer_count_low) + 8'h01)
      else $error("low byte did not count in split mode");

   a_high_gated_split: assert property (
      split_mode && !run_control && !wr_ch |=> $stable(timer_count_high))
      else $error("high byte counted without run");

   a_capture_copy: assert property (
      capture |=> {timer_reload_high, timer_reload_low} == $past({timer_count_high, timer_count_low}))
      else $error("capture did not copy the count");

   a_unused_zero: assert property (
      sfr_rd && sfr_addr == tmr_pkg::ADDR_CONTROL |=> !sfr_rdata[1])
      else $error("unused control bit read as one");

   a_low_irq: assert property (
      cpu_irq_enable && set_low && low_byte_irq_enable ##1 cpu_irq_enable && low_byte_irq_enable
      |=> irq_req)
      else $error("low overflow gave no interrupt");

   a_capture_irq: assert property (
      capture && cpu_irq_enable ##1 cpu_irq_enable |=> irq_req)
      else $error("capture gave no interrupt");

   a_flag_sticky: assert property (
      low_overflow_flag && !wr_ctrl |=> low_overflow_flag)
      else $error("low flag cleared by hardware");

   a_count_16: assert property (
      !split_mode && run_control && tick_low && !wr_cl && !wr_ch &&
      {timer_count_high, timer_count_low} != 16'hffff
      |=> {timer_count_high, timer_count_low} == $past({timer_count_high, timer_count_low}) + 16'h0001)
      else $error("16-bit counter did not step");

   a_split_low_reload: assert property (
      split_mode && tick_low && !wr_cl && timer_count_low == 8'hff
      |=> timer_count_low == $past(timer_reload_low) && low_overflow_flag)
      else $error("split low byte did not reload or flag");

   a_split_high_reload: assert property (
      split_mode && run_control && tick_high && !wr_ch && timer_count_high == 8'hff
      |=> timer_count_high == $past(timer_reload_high) && high_overflow_flag)
      else $error("split high byte did not reload or flag");

   a_reload_write: assert property (
      wr_rll && !capture |=> timer_reload_low == $past(sfr_wdata))
      else $error("low reload write lost");

   a_irq_level: assert property (
      1'b1 |=> irq_req == $past(cpu_irq_enable &&
                                (high_overflow_flag || (low_overflow_flag && low_byte_irq_enable))))
      else $error("interrupt request does not follow the flags");

   c_wrap_16: cover property (!split_mode && set_high && !capture);
   c_split_high: cover property (split_mode && set_high);
   c_capture: cover property (capture ##[1:20] capture);
   c_low_irq: cover property (set_low && low_byte_irq_enable && cpu_irq_enable);
   c_split_low: cover property (split_mode && set_low);

endmodule

`default_nettype wire

/* File: logic/tmr_unused_placeholder_none.sv */
// Intentionally empty: no further design content.
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: test/tmr_timer_tb.sv */
// Self-checking bench for the timer control and reload slice: register access, counting, capture, interrupt.
// Assumes the design package and tick interface are compiled first; inputs change on the falling clock edge.
`timescale 1ns/1ps
`default_nettype none

module tmr_timer_tb;

   // ****************************************
   // Signals and design instance
   // ****************************************
   logic       sys_clk;
   logic       resetn;
   logic [7:0] sfr_addr;
   logic       sfr_wr;
   logic       sfr_rd;
   logic [7:0] sfr_wdata;
   logic [7:0] sfr_rdata;
   logic       cpu_irq_enable;
   logic       high_byte_clock_select;
   logic       low_byte_clock_select;
   logic       ext_osc;
   logic       low_freq_oscillator;
   logic       irq_req;
   logic [1:0] osc_div;
   logic [7:0] rv;
   int         error_cnt;
   int         n_checks;

   tmr_timer tmr_timer_i (
      .sys_clk                (sys_clk),
      .resetn                 (resetn),
      .sfr_addr               (sfr_addr),
      .sfr_wr                 (sfr_wr),
      .sfr_rd                 (sfr_rd),
      .sfr_wdata              (sfr_wdata),
      .sfr_rdata              (sfr_rdata),
      .cpu_irq_enable         (cpu_irq_enable),
      .high_byte_clock_select (high_byte_clock_select),
      .low_byte_clock_select  (low_byte_clock_select),
      .ext_osc                (ext_osc),
      .low_freq_oscillator    (low_freq_oscillator),
      .irq_req                (irq_req)
   );

   // ****************************************
   // Clocks
   // ****************************************
   initial sys_clk = 1'b0;
   always #50 sys_clk = ~sys_clk;

   // External oscillator toggles every third core cycle
   always @(negedge sys_clk) begin
      if (osc_div == 2'h2) begin
         osc_div <= 2'h0;
         ext_osc <= ~ext_osc;
      end else begin
         osc_div <= osc_div + 2'h1;
      end
   end

   // ****************************************
   // Bus and compare tasks
   // ****************************************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr  = a;
      sfr_wdata = d;
      sfr_wr    = 1'b1;
      @(negedge sys_clk);
      sfr_wr    = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      sfr_addr = a;
      sfr_rd   = 1'b1;
      @(negedge sys_clk);
      sfr_rd   = 1'b0;
      d        = sfr_rdata;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rng(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
      n_checks++;
      if (!(got >= lo && got <= hi) || $isunknown(got)) begin
         error_cnt++;
         $display("MISMATCH t=%0t got %h outside %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      rd(a, d);
      chk(d, exp);
   endtask

   task automatic wait_cyc(input int n);
      repeat (n) @(negedge sys_clk);
   endtask

   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ****************************************
   // Watchdog
   // ****************************************
   initial begin
      #3ms;
      error_cnt++;
      $display("MISMATCH t=%0t watchdog expired", $time);
      give_verdict();
   end

   // ****************************************
   // Test sequence
   // ****************************************
   initial begin
      error_cnt = 0;
      n_checks = 0;
      resetn = 1'b0;
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_wdata = 8'h00;
      cpu_irq_enable = 1'b1;
      high_byte_clock_select = 1'b1;
      low_byte_clock_select = 1'b1;
      ext_osc = 1'b0;
      low_freq_oscillator = 1'b0;
      osc_div = 2'h0;
      wait_cyc(8);
      resetn = 1'b1;
      // Reset values and access
      rd_chk(tmp_addr(0), 8'h00);
      rd_chk(tmr_pkg::ADDR_RELOAD_LOW, 8'h00);
      rd_chk(tmr_pkg::ADDR_RELOAD_HIGH, 8'h00);
      rd_chk(tmr_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h02);
      rd_chk(tmr_pkg::ADDR_CONTROL, 8'h00);
      rd_chk(8'hc9, 8'h00);
      wr(tmr_pkg::ADDR_RELOAD_LOW, 8'h10);
      wr(tmr_pkg::ADDR_RELOAD_HIGH, 8'hab);
      rd_chk(tmr_pkg::ADDR_RELOAD_LOW, 8'h10);
      rd_chk(tmr_pkg::ADDR_RELOAD_HIGH, 8'hab);
      // Stopped 16-bit counter holds its value
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'h55);
      wait_cyc(30);
      rd_chk(tmr_pkg::ADDR_COUNT_LOW, 8'h55);
      // 16-bit rollover reloads and sets both flags
      wr(tmr_pkg::ADDR_COUNT_HIGH, 8'hff);
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'hfd);
      wr(tmr_pkg::ADDR_CONTROL, 8'h04);
      wait_cyc(10);
      rd_chk(tmr_pkg::ADDR_CONTROL, 8'hc4);
      chk({7'h00, irq_req}, 8'h01);
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      rd_chk(tmr_pkg::ADDR_COUNT_HIGH, 8'hab);
      wait_cyc(3);
      chk({7'h00, irq_req}, 8'h00);
      // Split mode: low byte runs without run control, high byte held
      wr(tmr_pkg::ADDR_COUNT_HIGH, 8'h20);
      wr(tmr_pkg::ADDR_RELOAD_LOW, 8'h80);
      wr(tmr_pkg::ADDR_CONTROL, 8'h08);
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'hfe);
      wait_cyc(10);
      rd_chk(tmr_pkg::ADDR_CONTROL, 8'h48);
      rd_chk(tmr_pkg::ADDR_COUNT_HIGH, 8'h20);
      rd(tmr_pkg::ADDR_COUNT_LOW, rv);
      chk_rng(rv, 8'h80, 8'h8f);
      chk({7'h00, irq_req}, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h68);
      wait_cyc(3);
      chk({7'h00, irq_req}, 8'h01);
      cpu_irq_enable = 1'b0;
      wait_cyc(3);
      chk({7'h00, irq_req}, 8'h00);
      cpu_irq_enable = 1'b1;
      // Split mode with run: high byte wraps to its own reload
      wr(tmr_pkg::ADDR_RELOAD_HIGH, 8'h40);
      wr(tmr_pkg::ADDR_COUNT_HIGH, 8'hfe);
      wr(tmr_pkg::ADDR_CONTROL, 8'h0c);
      wait_cyc(4);
      rd(tmr_pkg::ADDR_CONTROL, rv);
      chk(rv & 8'h80, 8'h80);
      rd(tmr_pkg::ADDR_COUNT_HIGH, rv);
      chk_rng(rv, 8'h40, 8'h4f);
      // Capture of a held count on an oscillator falling edge
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      wr(tmr_pkg::ADDR_COUNT_HIGH, 8'h5a);
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'hc3);
      wr(tmr_pkg::ADDR_CONTROL, 8'h10);
      low_freq_oscillator = 1'b1;
      wait_cyc(6);
      low_freq_oscillator = 1'b0;
      wait_cyc(8);
      rd_chk(tmr_pkg::ADDR_RELOAD_LOW, 8'hc3);
      rd_chk(tmr_pkg::ADDR_RELOAD_HIGH, 8'h5a);
      rd_chk(tmr_pkg::ADDR_CONTROL, 8'h90);
      chk({7'h00, irq_req}, 8'h01);
      wr(tmr_pkg::ADDR_CONTROL, 8'h10);
      wr(tmr_pkg::ADDR_RELOAD_LOW, 8'h00);
      wait_cyc(20);
      rd_chk(tmr_pkg::ADDR_CONTROL, 8'h10);
      rd_chk(tmr_pkg::ADDR_RELOAD_LOW, 8'h00);
      // Core clock divided by 12
      low_byte_clock_select = 1'b0;
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      wr(tmr_pkg::ADDR_COUNT_HIGH, 8'h00);
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h04);
      wait_cyc(119);
      wr(tmr_pkg::ADDR_CONTROL, 8'h00);
      rd(tmr_pkg::ADDR_COUNT_LOW, rv);
      chk_rng(rv, 8'h09, 8'h0b);
      // External oscillator divided by 8
      wr(tmr_pkg::ADDR_COUNT_LOW, 8'h00);
      wr(tmr_pkg::ADDR_CONTROL, 8'h05);
      wait_cyc(479);
      wr(tmr_pkg::ADDR_CONTROL, 8'h01);
      rd(tmr_pkg::ADDR_COUNT_LOW, rv);
      chk_rng(rv, 8'h09, 8'h0b);
      give_verdict();
   end

   function automatic logic [7:0] tmp_addr(input int i);
      return tmr_pkg::ADDR_CONTROL + 8'(i);
   endfunction

endmodule

`default_nettype wire
